/* rtl/timer16_consts.svh */
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

// Register byte offsets
`define T16_OFF_MODE 8'h00
`define T16_OFF_PRESC 8'h04
`define T16_OFF_CCC 8'h08
`define T16_OFF_OUTCTL 8'h0c
`define T16_OFF_CMPA 8'h10
`define T16_OFF_CMPB 8'h14
`define T16_OFF_COUNT 8'h18
`define T16_OFF_STATUS 8'h1c

// Field positions
`define T16_MODE_LO 2
`define T16_MODE_HI 3
`define T16_CLKSEL_LO 0
`define T16_CLKSEL_HI 1
`define T16_EDGE_LO 4
`define T16_EDGE_HI 5
`define T16_OC_ENABLE 0
`define T16_OC_TOGGLE_A 1
`define T16_OC_ONESHOT 5
`define T16_OC_SOFT_TRIG 6
`define T16_ST_OVF 0

// Reset values
`define T16_RST_MODE 8'h00
`define T16_RST_PRESC 8'h00
`define T16_RST_CCC 8'h00
`define T16_RST_OUTCTL 8'h00

// Prescaler masks: count tick every mask+1 clocks
`define T16_DIV_MASK0 5'h01
`define T16_DIV_MASK1 5'h07
`define T16_DIV_MASK2 5'h1f

`endif

/* rtl/timer16_pkg.sv */
package timer16_pkg;

    typedef enum logic [1:0] {
        op_stop = 2'b00,
        op_restart_edge = 2'b01,
        op_free_run = 2'b10,
        op_clear_match_a = 2'b11
    } op_mode_t;

    typedef enum logic [1:0] {
        edge_fall = 2'b00,
        edge_rise = 2'b01,
        edge_none = 2'b10,
        edge_both = 2'b11
    } edge_sel_t;

    typedef enum logic [2:0] {
        os_idle = 3'b001,
        os_wait = 3'b010,
        os_pulse = 3'b100
    } os_state_t;

endpackage : timer16_pkg

/* rtl/timer16_edge_filter.sv */
`timescale 1ns/1ps
`default_nettype none

module timer16_edge_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    input wire logic sample,
    input wire logic enable,
    output logic rise,
    output logic fall
);

    logic sync_a;
    logic sync_b;
    logic prev;
    logic level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
        end
    end

    // While stopped the level tracks the pin, so a restart sees no edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else if (!enable) begin
            prev <= sync_b;
            level <= sync_b;
            rise <= 1'b0;
            fall <= 1'b0;
        end else if (sample) begin
            prev <= sync_b;
            if (sync_b == prev && sync_b != level) begin
                level <= sync_b;
                rise <= sync_b;
                fall <= ~sync_b;
            end else begin
                rise <= 1'b0;
                fall <= 1'b0;
            end
        end else begin
            rise <= 1'b0;
            fall <= 1'b0;
        end
    end

endmodule : timer16_edge_filter

`default_nettype wire

/* rtl/timer16_capture_event_oneshot.sv */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.svh"

module timer16_capture_event_oneshot #(
    parameter int CNT_W = 16,
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_input_a,
    output logic timer_output_pin,
    output logic match_a_irq,
    output logic match_b_irq,
    output logic counter_overflow_flag
);
    import timer16_pkg::*;

    // Refused at elaboration: read mux and counter assume these ranges
    if (CNT_W < 2 || CNT_W > 32) begin : g_cnt_w_check
        $error("CNT_W must lie between 2 and 32");
    end
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
        $error("ADDR_W must lie between 8 and 32");
    end

    logic [7:0] mode_control_reg;
    logic [7:0] prescaler_mode_reg;
    logic [7:0] capture_compare_control;
    logic [7:0] output_control_reg;
    logic [CNT_W-1:0] compare_reg_a;
    logic [CNT_W-1:0] compare_reg_b;
    logic [CNT_W-1:0] up_counter16;
    logic soft_trig;
    logic [4:0] divider;
    os_state_t os_state;
    os_state_t next_os_state;

    logic [7:0] addr;
    logic wr_en;
    logic rd_phase;
    logic mapped;
    logic [31:0] rd_word;

    op_mode_t op_mode;
    edge_sel_t edge_sel;
    logic [1:0] clk_sel;
    logic running;
    logic event_mode;
    logic oneshot_en;
    logic [4:0] div_mask;
    logic presc_tick;
    logic cap_rise;
    logic cap_fall;
    logic ev_rise;
    logic ev_fall;
    logic cap_any;
    logic cap_one;
    logic ev_valid;
    logic tick;
    logic capture;
    logic ext_trig;
    logic soft_start;
    logic restart;
    logic step;
    logic hit_a;
    logic hit_b;
    logic wrap;
    logic first_hit;
    logic second_hit;
    logic all_ones_a;

    assign addr = paddr[7:0];
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_phase = psel & penable & ~pready;

    assign op_mode = op_mode_t'(mode_control_reg[`T16_MODE_HI:`T16_MODE_LO]);
    assign edge_sel =
        edge_sel_t'(prescaler_mode_reg[`T16_EDGE_HI:`T16_EDGE_LO]);
    assign clk_sel = prescaler_mode_reg[`T16_CLKSEL_HI:`T16_CLKSEL_LO];
    assign running = (op_mode != op_stop);
    assign event_mode = (clk_sel == 2'b11);
    assign oneshot_en = output_control_reg[`T16_OC_ONESHOT];

    always_comb begin
        case (clk_sel)
            2'b00: div_mask = `T16_DIV_MASK0;
            2'b01: div_mask = `T16_DIV_MASK1;
            2'b10: div_mask = `T16_DIV_MASK2;
            default: div_mask = `T16_DIV_MASK0;
        endcase
    end

    // Divider is held at zero while stopped so the first tick is fixed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider <= 5'h00;
        end else if (!running) begin
            divider <= 5'h00;
        end else begin
            divider <= divider + 5'h01;
        end
    end

    assign presc_tick = running && ((divider & div_mask) == div_mask);

    // Capture trigger sampled on prescaler tick, also in event mode
    timer16_edge_filter u_cap_filter (
        .pclk(pclk),
        .presetn(presetn),
        .pin(timer_input_a),
        .sample(presc_tick),
        .enable(running),
        .rise(cap_rise),
        .fall(cap_fall)
    );

    // Event input sampled every main clock
    timer16_edge_filter u_ev_filter (
        .pclk(pclk),
        .presetn(presetn),
        .pin(timer_input_a),
        .sample(1'b1),
        .enable(running),
        .rise(ev_rise),
        .fall(ev_fall)
    );

    // One edge only; both-edges falls back to rising
    assign cap_one = (edge_sel == edge_fall) ? cap_fall :
                     (edge_sel == edge_none) ? 1'b0 : cap_rise;
    // One-shot trigger edge selectable three ways
    assign cap_any = ((edge_sel == edge_rise) & cap_rise) |
                     ((edge_sel == edge_fall) & cap_fall) |
                     ((edge_sel == edge_both) & (cap_rise | cap_fall));
    assign ev_valid = ((edge_sel == edge_rise) & ev_rise) |
                      ((edge_sel == edge_fall) & ev_fall) |
                      ((edge_sel == edge_both) & (ev_rise | ev_fall));

    // Event mode counts filtered input edges
    assign tick = event_mode ? ev_valid : presc_tick;

    // Capture and restart on valid edge
    assign capture = running && (op_mode == op_restart_edge) &&
                     !oneshot_en && cap_one;
    // Input edge triggers in either one-shot flavour
    // Ignored until the pulse sequence is over
    assign ext_trig = running && (op_mode != op_clear_match_a) &&
                      oneshot_en && cap_any && (os_state == os_idle);
    assign soft_start = running && oneshot_en && soft_trig;
    assign restart = capture | ext_trig | soft_start;
    assign step = running && tick && !restart;

    assign all_ones_a = (compare_reg_a == {CNT_W{1'b1}});
    assign hit_a = step && (up_counter16 == compare_reg_a);
    assign hit_b = step && (up_counter16 == compare_reg_b);
    // In match-clear mode wrap needs A all ones
    assign wrap = step && (op_mode == op_clear_match_a ?
                  (hit_a && all_ones_a) :
                  (up_counter16 == {CNT_W{1'b1}}));

    // Counter runs on after the pulse until stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_counter16 <= {CNT_W{1'b0}};
        end else if (!running) begin
            up_counter16 <= {CNT_W{1'b0}};
        end else if (restart) begin
            up_counter16 <= {CNT_W{1'b0}};
        end else if (step) begin
            if (op_mode == op_clear_match_a && hit_a) begin
                up_counter16 <= {CNT_W{1'b0}};
            end else begin
                up_counter16 <= up_counter16 + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Smaller compare starts the pulse, larger ends it
    assign first_hit = (compare_reg_b < compare_reg_a) ? hit_b : hit_a;
    assign second_hit = (compare_reg_b < compare_reg_a) ? hit_a : hit_b;

    always_comb begin
        next_os_state = os_state;
        case (os_state)
            os_idle: begin
                if (restart) begin
                    next_os_state = os_wait;
                end
            end
            os_wait: begin
                if (first_hit) begin
                    next_os_state = os_pulse;
                end
            end
            os_pulse: begin
                if (soft_start) begin
                    next_os_state = os_wait;
                end else if (second_hit) begin
                    next_os_state = os_idle;
                end
            end
            default: next_os_state = os_idle;
        endcase
        if (!running || !oneshot_en) begin
            next_os_state = os_idle;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            os_state <= os_idle;
        end else begin
            os_state <= next_os_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_output_pin <= 1'b0;
        end else if (!output_control_reg[`T16_OC_ENABLE]) begin
            timer_output_pin <= 1'b0;
        end else if (oneshot_en) begin
            timer_output_pin <= (next_os_state == os_pulse);
        end else if (output_control_reg[`T16_OC_TOGGLE_A] && hit_a) begin
            // Invert on each compare A match
            timer_output_pin <= ~timer_output_pin;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_a_irq <= 1'b0;
            match_b_irq <= 1'b0;
        end else begin
            match_a_irq <= hit_a;
            match_b_irq <= capture | (hit_b &&
                !(op_mode == op_restart_edge && !oneshot_en));
        end
    end

    // A wrap in the same cycle as a clear keeps the flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_overflow_flag <= 1'b0;
        end else if (wrap) begin
            counter_overflow_flag <= 1'b1;
        end else if (wr_en && addr == `T16_OFF_STATUS &&
                     pwdata[`T16_ST_OVF]) begin
            counter_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_control_reg <= `T16_RST_MODE;
            prescaler_mode_reg <= `T16_RST_PRESC;
            capture_compare_control <= `T16_RST_CCC;
            output_control_reg <= `T16_RST_OUTCTL;
            compare_reg_a <= {CNT_W{1'b0}};
        end else if (wr_en) begin
            case (addr)
                `T16_OFF_MODE: mode_control_reg <= pwdata[7:0] & 8'h0c;
                `T16_OFF_PRESC: prescaler_mode_reg <= pwdata[7:0] & 8'h33;
                `T16_OFF_CCC: capture_compare_control <= pwdata[7:0];
                `T16_OFF_OUTCTL: output_control_reg <= pwdata[7:0] & 8'h23;
                `T16_OFF_CMPA: compare_reg_a <= pwdata[CNT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Capture wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_reg_b <= {CNT_W{1'b0}};
        end else if (capture) begin
            compare_reg_b <= up_counter16;
        end else if (wr_en && addr == `T16_OFF_CMPB) begin
            compare_reg_b <= pwdata[CNT_W-1:0];
        end
    end

    // Trigger bit is a strobe only and always reads back as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_trig <= 1'b0;
        end else begin
            soft_trig <= wr_en && addr == `T16_OFF_OUTCTL &&
                         pwdata[`T16_OC_SOFT_TRIG];
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        mapped = 1'b1;
        case (addr)
            `T16_OFF_MODE: rd_word[7:0] = mode_control_reg;
            `T16_OFF_PRESC: rd_word[7:0] = prescaler_mode_reg;
            `T16_OFF_CCC: rd_word[7:0] = capture_compare_control;
            `T16_OFF_OUTCTL: rd_word[7:0] = output_control_reg;
            `T16_OFF_CMPA: rd_word[CNT_W-1:0] = compare_reg_a;
            `T16_OFF_CMPB: rd_word[CNT_W-1:0] = compare_reg_b;
            `T16_OFF_COUNT: rd_word[CNT_W-1:0] = up_counter16;
            `T16_OFF_STATUS: rd_word[`T16_ST_OVF] = counter_overflow_flag;
            default: mapped = 1'b0;
        endcase
        if (paddr[ADDR_W-1:2] != {{(ADDR_W-8){1'b0}}, paddr[7:2]}) begin
            mapped = 1'b0;
            rd_word = 32'h0000_0000;
        end
    end

    // One wait state keeps every bus output on a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (rd_phase) begin
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= pwrite ? 32'h0000_0000 : rd_word;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

endmodule : timer16_capture_event_oneshot

`default_nettype wire

/* testbench/timer16_capture_event_oneshot_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module timer16_capture_event_oneshot_checker #(
    parameter int CNT_W = 16,
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_input_a,
    input wire logic timer_output_pin,
    input wire logic match_a_irq,
    input wire logic match_b_irq,
    input wire logic counter_overflow_flag
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence wait_state_s;
        psel && penable && !pready;
    endsequence

    sequence answer_s;
        psel && penable && pready;
    endsequence

    one_wait_a: assert property (wait_state_s |=> answer_s)
        else $error("access phase not answered after one wait");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_in_access_a: assert property (pready |-> $past(penable) && psel)
        else $error("pready outside an access phase");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    irq_a_pulse_a: assert property (match_a_irq |=> !match_a_irq)
        else $error("match A request longer than one cycle");
    irq_b_pulse_a: assert property (match_b_irq |=> !match_b_irq)
        else $error("match B request longer than one cycle");
    wr_rdata_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("prdata not zero in a write answer");
endmodule : timer16_capture_event_oneshot_checker

bind timer16_capture_event_oneshot timer16_capture_event_oneshot_checker #(
    .CNT_W(CNT_W), .ADDR_W(ADDR_W)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_a(timer_input_a),
    .timer_output_pin(timer_output_pin), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq),
    .counter_overflow_flag(counter_overflow_flag));

`default_nettype wire

/* testbench/timer16_pulse_src.sv */
`timescale 1ns/1ps
`default_nettype none

module timer16_pulse_src (
    input wire logic pclk,
    input wire logic load,
    output var logic line
);
    int rises = 0;
    logic load_q = 1'b0;

    initial line = 1'b0;

    // Load side only counts pulses seen on the output
    always @(posedge pclk) begin
        load_q <= load;
        if (load === 1'b1 && load_q === 1'b0) rises <= rises + 1;
    end

    task automatic pulse(input int hi, input int lo);
        @(posedge pclk);
        line <= 1'b1;
        repeat (hi) @(posedge pclk);
        line <= 1'b0;
        repeat (lo) @(posedge pclk);
    endtask : pulse
endmodule : timer16_pulse_src

`default_nettype wire

/* testbench/timer16_capture_event_oneshot_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, got, exp); end end

module timer16_capture_event_oneshot_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    wire logic timer_input_a;
    logic timer_output_pin;
    logic match_a_irq;
    logic match_b_irq;
    logic counter_overflow_flag;
    int err_total = 0;
    int samples_checked = 0;
    int na = 0;
    int nb = 0;
    int c;
    logic [31:0] rq;
    logic rerr;

    timer16_capture_event_oneshot uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_input_a(timer_input_a),
        .timer_output_pin(timer_output_pin), .match_a_irq(match_a_irq),
        .match_b_irq(match_b_irq),
        .counter_overflow_flag(counter_overflow_flag));
    timer16_pulse_src src (.pclk(pclk), .load(timer_output_pin),
        .line(timer_input_a));

    always #2 pclk = ~pclk;

    always @(posedge pclk) begin
        if (match_a_irq === 1'b1) na <= na + 1;
        if (match_b_irq === 1'b1) nb <= nb + 1;
    end

    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 10; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 10) begin
            err_total++;
            wrap_up();
        end
        rq = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic setup(input logic [7:0] ps, input logic [7:0] oc,
                         input logic [15:0] ca, input logic [15:0] cb,
                         input logic [7:0] md);
        wr(`T16_OFF_MODE, 32'h0);
        wr(`T16_OFF_PRESC, {24'h0, ps});
        wr(`T16_OFF_CCC, 32'h0);
        wr(`T16_OFF_OUTCTL, {24'h0, oc});
        wr(`T16_OFF_CMPA, {16'h0, ca});
        wr(`T16_OFF_CMPB, {16'h0, cb});
        wr(`T16_OFF_MODE, {24'h0, md});
    endtask : setup

    task automatic wait_pin(input logic lvl);
        c = 0;
        while (timer_output_pin !== lvl && c < 3000) begin
            @(posedge pclk);
            c++;
        end
        if (c == 3000) begin
            err_total++;
            wrap_up();
        end
    endtask : wait_pin

    task automatic t_regs;
        for (int k = 0; k < 4; k++) begin
            rd(8'(k * 4));
            `CHK(rq, 32'h0)
        end
        wr(`T16_OFF_CCC, 32'ha5);
        rd(`T16_OFF_CCC);
        `CHK(rq, 32'ha5)
        rd(8'h20);
        `CHK(rerr, 1'b1)
        wr(`T16_OFF_STATUS, 32'h1);
        `CHK(counter_overflow_flag, 1'b0)
        `CHK(timer_output_pin, 1'b0)
        $display("regs test done");
    endtask : t_regs

    task automatic t_event;
        logic [7:0] ps [3] = '{8'h03, 8'h13, 8'h33};
        int ex [3] = '{2, 2, 4};
        int a0;
        for (int k = 0; k < 3; k++) begin
            setup(ps[k], 8'h00, 16'd5, 16'd7, 8'h0c);
            src.pulse(1, 6);
            repeat (2) src.pulse(4, 4);
            repeat (6) @(posedge pclk);
            rd(`T16_OFF_COUNT);
            `CHK(rq, 32'(ex[k]))
        end
        setup(8'h13, 8'h00, 16'd3, 16'd7, 8'h0c);
        a0 = na;
        repeat (4) src.pulse(4, 4);
        repeat (6) @(posedge pclk);
        `CHK(na - a0, 1)
        `CHK(counter_overflow_flag, 1'b0)
        rd(`T16_OFF_COUNT);
        `CHK(rq, 32'h0)
        $display("event test done");
    endtask : t_event

    task automatic t_restart;
        logic [7:0] ps [3] = '{8'h20, 8'h00, 8'h10};
        int ex [3] = '{0, 2, 2};
        int b0;
        for (int k = 0; k < 3; k++) begin
            setup(ps[k], 8'h00, 16'd9, 16'd9, 8'h04);
            b0 = nb;
            src.pulse(1, 20);
            repeat (2) src.pulse(20, 20);
            `CHK(nb - b0, ex[k])
        end
        rd(`T16_OFF_CMPB);
        `CHK(rq >= 18 && rq <= 21, 1'b1)
        $display("restart test done");
    endtask : t_restart

    task automatic t_square;
        setup(8'h00, 8'h03, 16'd3, 16'd9, 8'h0c);
        wait_pin(1'b1);
        wait_pin(1'b0);
        `CHK(c, 8)
        wait_pin(1'b1);
        `CHK(c, 8)
        $display("square test done");
    endtask : t_square

    task automatic t_soft;
        logic [15:0] av [2] = '{16'd10, 16'd4};
        logic [31:0] q0;
        for (int k = 0; k < 2; k++) begin
            setup(8'h00, 8'h21, av[k], av[1-k], 8'h08);
            rd(`T16_OFF_COUNT);
            `CHK(rq != 32'h0, 1'b1)
            repeat (20) @(posedge pclk);
            `CHK(timer_output_pin, 1'b0)
            // trigger only while no pulse is out
            wr(`T16_OFF_OUTCTL, 32'h61);
            wait_pin(1'b1);
            wait_pin(1'b0);
            `CHK(c, 12)
        end
        rd(`T16_OFF_COUNT);
        q0 = rq;
        rd(`T16_OFF_COUNT);
        `CHK(rq > q0, 1'b1)
        // Input fall still triggers while in software one-shot
        src.pulse(8, 1);
        wait_pin(1'b1);
        wait_pin(1'b0);
        `CHK(c, 12)
        $display("soft one-shot test done");
    endtask : t_soft

    task automatic t_ext;
        logic [7:0] ps [3] = '{8'h00, 8'h10, 8'h30};
        int r0;
        for (int k = 0; k < 3; k++) begin
            setup(ps[k], 8'h21, 16'd40, 16'd4, 8'h04);
            r0 = src.rises;
            src.pulse(4, 4);
            wait_pin(1'b1);
            // Second trigger while the pulse is out must not restart it
            src.pulse(4, 4);
            wait_pin(1'b0);
            `CHK(c, 63)
            `CHK(src.rises - r0, 1)
        end
        $display("external one-shot test done");
    endtask : t_ext

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_event();
        t_restart();
        t_square();
        t_soft();
        t_ext();
        wrap_up();
    end
endmodule : timer16_capture_event_oneshot_tb

`default_nettype wire
